//--- core/flash_read_pkg.sv
// constants, types and parameter table values for the serial flash read path
package flash_read_pkg;
   // ==========================================
   // modes, states and carriers
   typedef enum logic [1:0] {PROTO_EXT = 2'h0, PROTO_DUAL = 2'h1, PROTO_QUAD = 2'h2} proto_t;
   typedef enum logic [2:0] {
      ST_CMD = 3'h0, ST_ADDR = 3'h1, ST_DUMMY = 3'h3, ST_DATA = 3'h2, ST_REJECT = 3'h6
   } link_state_t;
   typedef enum logic [2:0] {
      K_READ = 3'h0, K_FAST = 3'h1, K_DOUT = 3'h2, K_DIO = 3'h3, K_QOUT = 3'h4, K_QIO = 3'h5
   } cmd_kind_t;
   typedef struct packed {
      proto_t proto;
      logic dtr;
      logic addr4;
      logic [7:0] ext_addr;
   } link_cfg_t;
   typedef struct packed {
      logic ok;
      logic [2:0] addr_w;
      logic [2:0] data_w;
      logic [3:0] dummy;
   } cmd_attr_t;
   // ==========================================
   // command codes
   localparam logic [7:0] CMD_READ = 8'h03;
   localparam logic [7:0] CMD_FAST = 8'h0b;
   localparam logic [7:0] CMD_DOUT = 8'h3b;
   localparam logic [7:0] CMD_DIO = 8'hbb;
   localparam logic [7:0] CMD_QOUT = 8'h6b;
   localparam logic [7:0] CMD_QIO = 8'heb;
   localparam logic [7:0] CMD_FAST_DTR = 8'h0d;
   localparam logic [7:0] CMD_DOUT_DTR = 8'h3d;
   localparam logic [7:0] CMD_DIO_DTR = 8'hbd;
   localparam logic [7:0] CMD_QOUT_DTR = 8'h6d;
   localparam logic [7:0] CMD_QIO_DTR = 8'hed;
   // ==========================================
   // dummy cycles and frame widths
   localparam logic [3:0] DUMMY_NONE = 4'h0;
   localparam logic [3:0] DUMMY_FAST_EXT = 4'h8;
   localparam logic [3:0] DUMMY_FAST_DUAL = 4'h7;
   localparam logic [3:0] DUMMY_FAST_QUAD = 4'h9;
   localparam logic [3:0] DUMMY_DOUT = 4'h8;
   localparam logic [3:0] DUMMY_DIO = 4'h7;
   localparam logic [3:0] DUMMY_QOUT = 4'h7;
   localparam logic [3:0] DUMMY_QIO = 4'h9;
   localparam logic [5:0] CMD_BITS = 6'h08;
   localparam logic [5:0] ADDR3_BITS = 6'h18;
   localparam logic [5:0] ADDR4_BITS = 6'h20;
   localparam logic [3:0] BYTE_BITS = 4'h8;
   localparam int MEM_ADDR_W = 25;
   localparam logic [3:0] OE_SINGLE = 4'h2;
   localparam logic [3:0] OE_DUAL = 4'h3;
   localparam logic [3:0] OE_QUAD = 4'hf;
   // ==========================================
   // parameter table bytes
   localparam logic [7:0] PT_BLANK = 8'hff;
   localparam logic [7:0] PT_ABSENT = 8'h00;
   localparam logic [7:0] PT_QIO_DUMMY = 8'h29;
   localparam logic [7:0] PT_QIO_CODE = 8'heb;
   localparam logic [7:0] PT_QOUT_DUMMY = 8'h27;
   localparam logic [7:0] PT_QOUT_CODE = 8'h6b;
   localparam logic [7:0] PT_DOUT_DUMMY = 8'h08;
   localparam logic [7:0] PT_DOUT_CODE = 8'h3b;
   localparam logic [7:0] PT_DIO_DUMMY = 8'h27;
   localparam logic [7:0] PT_DIO_CODE = 8'hbb;
   localparam logic [7:0] PT_PROTO_SUPPORT = 8'hff;
   localparam logic [7:0] PT_DUAL_DUMMY = 8'h27;
   localparam logic [7:0] PT_DUAL_CODE = 8'hbb;
   localparam logic [7:0] PT_QUAD_DUMMY = 8'h29;
   localparam logic [7:0] PT_QUAD_CODE = 8'heb;
   localparam logic [7:0] PT_SECT1_SIZE = 8'h0c;
   localparam logic [7:0] PT_SECT1_CODE = 8'h20;
   localparam logic [7:0] PT_SECT2_SIZE = 8'h10;
   localparam logic [7:0] PT_SECT2_CODE = 8'hd8;
endpackage : flash_read_pkg

//--- core/serial_flash_read_path.sv
// read path of a serial flash: command, address, dummy and data streaming
`timescale 1ns/1ps
// Operation
// - three address bytes by default after reset
// - four-byte addressing by setting or commands
// - extended address register supplies upper byte
// - sample command and address on rising edge
// - address advances after every data byte
// - deselect stops driving and ends read
// - decode single edge rate read codes
// - decode double edge rate read codes
// - each protocol accepts only its commands
// - extended protocol line usage per command
// - dual and quad protocols use all lines
// - fast reads insert dummy cycles
// - table dual io dummy count seven
// - table dual protocol dummy count seven
// - table quad protocol dummy count nine
// - table confirmation bit count one
// - table dual io code at 3fh
// - table protocol fast read codes
// - table protocol support flags, reserved ones
// - table erase sector types
// - table quad and dual output dummies
// - table quad io dummy and code
module serial_flash_read_path (
   input wire logic I_CLK_SYS,
   input wire logic I_RESET,
   input wire logic I_SCK,
   input wire logic I_CS_N,
   input wire logic [3:0] I_DQ,
   output logic [3:0] O_DQ,
   output logic [3:0] O_DQ_OE,
   output logic [flash_read_pkg::MEM_ADDR_W-1:0] O_MEM_ADDR,
   input wire logic [7:0] I_MEM_DATA,
   input wire logic [1:0] I_PROTOCOL,
   input wire logic I_DTR,
   input wire logic I_ADDR4_NV,
   input wire logic I_ADDR4_ENTER,
   input wire logic I_ADDR4_EXIT,
   input wire logic [7:0] I_EXT_ADDR,
   input wire logic [7:0] I_PARAM_ADDR,
   output logic [7:0] O_PARAM_DATA,
   output logic O_ADDR4,
   output logic O_READ_ACTIVE
);
   // ==========================================
   // helpers
   function automatic logic [2:0] proto_width(input flash_read_pkg::proto_t p);
      case (p)
         flash_read_pkg::PROTO_DUAL: proto_width = 3'h2;
         flash_read_pkg::PROTO_QUAD: proto_width = 3'h4;
         default: proto_width = 3'h1;
      endcase
   endfunction : proto_width

   function automatic flash_read_pkg::cmd_attr_t decode(input logic [7:0] c,
                                                        input flash_read_pkg::link_cfg_t cfg);
      flash_read_pkg::cmd_attr_t a;
      flash_read_pkg::cmd_kind_t k;
      logic hit;
      a = '0;
      k = flash_read_pkg::K_READ;
      hit = 1'b0;
      case (c)
         flash_read_pkg::CMD_READ: begin hit = !cfg.dtr; k = flash_read_pkg::K_READ; end
         flash_read_pkg::CMD_FAST: begin hit = !cfg.dtr; k = flash_read_pkg::K_FAST; end
         flash_read_pkg::CMD_DOUT: begin hit = !cfg.dtr; k = flash_read_pkg::K_DOUT; end
         flash_read_pkg::CMD_DIO: begin hit = !cfg.dtr; k = flash_read_pkg::K_DIO; end
         flash_read_pkg::CMD_QOUT: begin hit = !cfg.dtr; k = flash_read_pkg::K_QOUT; end
         flash_read_pkg::CMD_QIO: begin hit = !cfg.dtr; k = flash_read_pkg::K_QIO; end
         flash_read_pkg::CMD_FAST_DTR: begin hit = cfg.dtr; k = flash_read_pkg::K_FAST; end
         flash_read_pkg::CMD_DOUT_DTR: begin hit = cfg.dtr; k = flash_read_pkg::K_DOUT; end
         flash_read_pkg::CMD_DIO_DTR: begin hit = cfg.dtr; k = flash_read_pkg::K_DIO; end
         flash_read_pkg::CMD_QOUT_DTR: begin hit = cfg.dtr; k = flash_read_pkg::K_QOUT; end
         flash_read_pkg::CMD_QIO_DTR: begin hit = cfg.dtr; k = flash_read_pkg::K_QIO; end
         default: hit = 1'b0;
      endcase
      // extended protocol line usage and dummy counts
      case (k)
         flash_read_pkg::K_FAST: begin a.addr_w = 3'h1; a.data_w = 3'h1; a.dummy = flash_read_pkg::DUMMY_FAST_EXT; end
         flash_read_pkg::K_DOUT: begin a.addr_w = 3'h1; a.data_w = 3'h2; a.dummy = flash_read_pkg::DUMMY_DOUT; end
         flash_read_pkg::K_DIO: begin a.addr_w = 3'h2; a.data_w = 3'h2; a.dummy = flash_read_pkg::DUMMY_DIO; end
         flash_read_pkg::K_QOUT: begin a.addr_w = 3'h1; a.data_w = 3'h4; a.dummy = flash_read_pkg::DUMMY_QOUT; end
         flash_read_pkg::K_QIO: begin a.addr_w = 3'h4; a.data_w = 3'h4; a.dummy = flash_read_pkg::DUMMY_QIO; end
         default: begin a.addr_w = 3'h1; a.data_w = 3'h1; a.dummy = flash_read_pkg::DUMMY_NONE; end
      endcase
      case (cfg.proto)
         flash_read_pkg::PROTO_EXT: a.ok = hit;
         flash_read_pkg::PROTO_DUAL: begin
            a.ok = hit && (k == flash_read_pkg::K_FAST || k == flash_read_pkg::K_DOUT || k == flash_read_pkg::K_DIO);
            a.addr_w = 3'h2;
            a.data_w = 3'h2;
            if (k == flash_read_pkg::K_FAST) begin
               a.dummy = flash_read_pkg::DUMMY_FAST_DUAL;
            end
         end
         flash_read_pkg::PROTO_QUAD: begin
            a.ok = hit && (k == flash_read_pkg::K_FAST || k == flash_read_pkg::K_QOUT || k == flash_read_pkg::K_QIO);
            a.addr_w = 3'h4;
            a.data_w = 3'h4;
            if (k == flash_read_pkg::K_FAST) begin
               a.dummy = flash_read_pkg::DUMMY_FAST_QUAD;
            end
         end
         default: a.ok = 1'b0;
      endcase
      decode = a;
   endfunction : decode

   // returns {output enable, line values} for the top bits of a byte
   function automatic logic [7:0] lanes(input logic [7:0] b, input logic [2:0] w);
      case (w)
         3'h2: lanes = {flash_read_pkg::OE_DUAL, 2'h0, b[7:6]};
         3'h4: lanes = {flash_read_pkg::OE_QUAD, b[7:4]};
         default: lanes = {flash_read_pkg::OE_SINGLE, 2'h0, b[7], 1'b0};
      endcase
   endfunction : lanes

   function automatic logic [31:0] shift_in(input logic [31:0] sr, input logic [2:0] w, input logic [3:0] dq);
      case (w)
         3'h2: shift_in = {sr[29:0], dq[1:0]};
         3'h4: shift_in = {sr[27:0], dq[3:0]};
         default: shift_in = {sr[30:0], dq[0]};
      endcase
   endfunction : shift_in

   function automatic logic [7:0] param_byte(input logic [7:0] a);
      case (a)
         8'h38: param_byte = flash_read_pkg::PT_QIO_DUMMY;
         8'h39: param_byte = flash_read_pkg::PT_QIO_CODE;
         8'h3a: param_byte = flash_read_pkg::PT_QOUT_DUMMY;
         8'h3b: param_byte = flash_read_pkg::PT_QOUT_CODE;
         8'h3c: param_byte = flash_read_pkg::PT_DOUT_DUMMY;
         8'h3d: param_byte = flash_read_pkg::PT_DOUT_CODE;
         8'h3e: param_byte = flash_read_pkg::PT_DIO_DUMMY;
         8'h3f: param_byte = flash_read_pkg::PT_DIO_CODE;
         8'h40: param_byte = flash_read_pkg::PT_PROTO_SUPPORT;
         8'h46: param_byte = flash_read_pkg::PT_DUAL_DUMMY;
         8'h47: param_byte = flash_read_pkg::PT_DUAL_CODE;
         8'h4a: param_byte = flash_read_pkg::PT_QUAD_DUMMY;
         8'h4b: param_byte = flash_read_pkg::PT_QUAD_CODE;
         8'h4c: param_byte = flash_read_pkg::PT_SECT1_SIZE;
         8'h4d: param_byte = flash_read_pkg::PT_SECT1_CODE;
         8'h4e: param_byte = flash_read_pkg::PT_SECT2_SIZE;
         8'h4f: param_byte = flash_read_pkg::PT_SECT2_CODE;
         8'h50, 8'h51, 8'h52, 8'h53: param_byte = flash_read_pkg::PT_ABSENT;
         default: param_byte = flash_read_pkg::PT_BLANK;
      endcase
   endfunction : param_byte

   // ==========================================
   // system domain: address mode, table, status
   logic addr4;
   flash_read_pkg::link_cfg_t cfg_sys;
   logic act_meta;
   logic act_sync;
   logic active;

   always_ff @(posedge I_CLK_SYS) begin
      if (I_RESET) begin
         addr4 <= I_ADDR4_NV;
      end else if (I_ADDR4_ENTER) begin
         addr4 <= 1'b1;
      end else if (I_ADDR4_EXIT) begin
         addr4 <= 1'b0;
      end
   end

   always_ff @(posedge I_CLK_SYS) begin
      if (I_RESET) begin
         cfg_sys <= '0;
      end else begin
         cfg_sys <= '{proto: flash_read_pkg::proto_t'(I_PROTOCOL), dtr: I_DTR, addr4: addr4, ext_addr: I_EXT_ADDR};
      end
   end

   always_ff @(posedge I_CLK_SYS) begin
      if (I_RESET) begin
         O_PARAM_DATA <= flash_read_pkg::PT_BLANK;
      end else begin
         O_PARAM_DATA <= param_byte(I_PARAM_ADDR);
      end
   end

   always_ff @(posedge I_CLK_SYS) begin
      if (I_RESET) begin
         act_meta <= 1'b0;
         act_sync <= 1'b0;
      end else begin
         act_meta <= active;
         act_sync <= act_meta;
      end
   end

   assign O_ADDR4 = addr4;
   assign O_READ_ACTIVE = act_sync;

   // ==========================================
   // link domain: configuration crossing
   // settings are quasi-static; the host gives two clocks with select high after a change
   flash_read_pkg::link_cfg_t cfg_meta;
   flash_read_pkg::link_cfg_t cfg_link;

   always_ff @(posedge I_SCK) begin
      cfg_meta <= cfg_sys;
      cfg_link <= cfg_meta;
   end

   // ==========================================
   // link domain: command, address and dummy phases
   flash_read_pkg::link_state_t state;
   flash_read_pkg::cmd_attr_t attr;
   flash_read_pkg::cmd_attr_t next_attr;
   logic [31:0] sr;
   logic [31:0] next_sr;
   logic [5:0] bit_cnt;
   logic [5:0] next_cnt;
   logic [3:0] dummy_cnt;
   logic [2:0] in_w;
   logic cmd_done;
   logic addr_done;
   logic [31:0] full_addr;
   logic [7:0] shift;
   logic [3:0] bits_left;
   logic load;
   logic [3:0] dq_out;
   logic [3:0] dq_oe;
   logic [flash_read_pkg::MEM_ADDR_W-1:0] mem_addr;

   always_comb begin
      in_w = (state == flash_read_pkg::ST_CMD) ? proto_width(cfg_link.proto) : attr.addr_w;
      next_sr = shift_in(sr, in_w, I_DQ);
      next_cnt = bit_cnt + {3'h0, in_w};
      next_attr = decode(next_sr[7:0], cfg_link);
      cmd_done = (state == flash_read_pkg::ST_CMD) && (next_cnt == flash_read_pkg::CMD_BITS);
      addr_done = (state == flash_read_pkg::ST_ADDR) &&
                  (next_cnt == (cfg_link.addr4 ? flash_read_pkg::ADDR4_BITS : flash_read_pkg::ADDR3_BITS));
      full_addr = cfg_link.addr4 ? next_sr : {cfg_link.ext_addr, next_sr[23:0]};
      load = (state == flash_read_pkg::ST_DATA) && (bits_left == 4'h0);
   end

   // deselect clears the frame at once, even with the serial clock stopped
   always_ff @(posedge I_SCK or posedge I_CS_N) begin
      if (I_CS_N) begin
         state <= flash_read_pkg::ST_CMD;
         sr <= '0;
         bit_cnt <= 6'h00;
         attr <= '0;
         dummy_cnt <= 4'h0;
      end else begin
         case (state)
            flash_read_pkg::ST_CMD: begin
               sr <= next_sr;
               if (cmd_done) begin
                  bit_cnt <= 6'h00;
                  attr <= next_attr;
                  state <= next_attr.ok ? flash_read_pkg::ST_ADDR : flash_read_pkg::ST_REJECT;
               end else begin
                  bit_cnt <= next_cnt;
               end
            end
            flash_read_pkg::ST_ADDR: begin
               sr <= next_sr;
               bit_cnt <= next_cnt;
               if (addr_done) begin
                  dummy_cnt <= attr.dummy;
                  state <= (attr.dummy == 4'h0) ? flash_read_pkg::ST_DATA : flash_read_pkg::ST_DUMMY;
               end
            end
            flash_read_pkg::ST_DUMMY: begin
               dummy_cnt <= dummy_cnt - 4'h1;
               if (dummy_cnt == 4'h1) begin
                  state <= flash_read_pkg::ST_DATA;
               end
            end
            flash_read_pkg::ST_DATA: state <= flash_read_pkg::ST_DATA;
            flash_read_pkg::ST_REJECT: state <= flash_read_pkg::ST_REJECT;
            default: state <= flash_read_pkg::ST_REJECT;
         endcase
      end
   end

   always_ff @(posedge I_SCK or posedge I_CS_N) begin
      if (I_CS_N) begin
         active <= 1'b0;
      end else begin
         active <= 1'b1;
      end
   end

   // ==========================================
   // link domain: data streaming
   always_ff @(posedge I_SCK or posedge I_CS_N) begin
      if (I_CS_N) begin
         mem_addr <= '0;
      end else if (addr_done) begin
         mem_addr <= full_addr[flash_read_pkg::MEM_ADDR_W-1:0];
      end else if (load) begin
         mem_addr <= mem_addr + {{(flash_read_pkg::MEM_ADDR_W - 1){1'b0}}, 1'b1};
      end
   end

   always_ff @(posedge I_SCK or posedge I_CS_N) begin
      if (I_CS_N) begin
         dq_out <= 4'h0;
         dq_oe <= 4'h0;
         shift <= 8'h00;
         bits_left <= 4'h0;
      end else if (load) begin
         {dq_oe, dq_out} <= lanes(I_MEM_DATA, attr.data_w);
         shift <= I_MEM_DATA << attr.data_w;
         bits_left <= flash_read_pkg::BYTE_BITS - {1'b0, attr.data_w};
      end else if (state == flash_read_pkg::ST_DATA) begin
         {dq_oe, dq_out} <= lanes(shift, attr.data_w);
         shift <= shift << attr.data_w;
         bits_left <= bits_left - {1'b0, attr.data_w};
      end
   end

   assign O_DQ = dq_out;
   assign O_DQ_OE = dq_oe;
   assign O_MEM_ADDR = mem_addr;

   // ==========================================
   // checks
   mode_reset_a: assert property (@(posedge I_CLK_SYS) disable iff (I_RESET)
      $fell(I_RESET) && !$past(I_ADDR4_NV) |-> !addr4) else $error("address mode not three bytes after reset");
   mode_enter_a: assert property (@(posedge I_CLK_SYS) disable iff (I_RESET)
      I_ADDR4_ENTER |=> addr4 [*1] ##0 O_ADDR4) else $error("four byte mode not entered");
   reject_cmd_a: assert property (@(posedge I_SCK) disable iff (I_CS_N)
      cmd_done && !next_attr.ok |=> state == flash_read_pkg::ST_REJECT ##1 dq_oe == 4'h0)
      else $error("unsupported command not rejected");
   no_dummy_a: assert property (@(posedge I_SCK) disable iff (I_CS_N)
      addr_done && attr.dummy == 4'h0 |=> load ##1 dq_oe != 4'h0) else $error("plain read delayed");
   dummy_len_a: assert property (@(posedge I_SCK) disable iff (I_CS_N)
      addr_done && attr.dummy == 4'h8 |=> (dq_oe == 4'h0) [*8] ##1 dq_oe == 4'h0 ##1 dq_oe != 4'h0)
      else $error("dummy count wrong");
   quiet_drive_a: assert property (@(posedge I_SCK) disable iff (I_CS_N)
      state != flash_read_pkg::ST_DATA |=> dq_oe == 4'h0) else $error("data driven outside data phase");
   addr_step_a: assert property (@(posedge I_SCK) disable iff (I_CS_N)
      load |=> mem_addr == $past(mem_addr) + {{(flash_read_pkg::MEM_ADDR_W - 1){1'b0}}, 1'b1})
      else $error("read address did not advance");
   msb_first_a: assert property (@(posedge I_SCK) disable iff (I_CS_N)
      load && attr.data_w == 3'h4 |=> dq_out == $past(I_MEM_DATA[7:4]) ##1 dq_out == $past(I_MEM_DATA[3:0], 2))
      else $error("quad byte order wrong");
   single_line_a: assert property (@(posedge I_SCK) disable iff (I_CS_N)
      load && attr.data_w == 3'h1 |=> dq_oe == flash_read_pkg::OE_SINGLE) else $error("single data not on line 1");
   table_dio_a: assert property (@(posedge I_CLK_SYS) disable iff (I_RESET)
      I_PARAM_ADDR == 8'h3e |=> O_PARAM_DATA == 8'h27) else $error("dual io dummy entry wrong");
   table_quad_a: assert property (@(posedge I_CLK_SYS) disable iff (I_RESET)
      I_PARAM_ADDR == 8'h4a |=> O_PARAM_DATA == 8'h29) else $error("quad dummy entry wrong");
   table_flags_a: assert property (@(posedge I_CLK_SYS) disable iff (I_RESET)
      I_PARAM_ADDR == 8'h40 |=> O_PARAM_DATA == 8'hff) else $error("support flags entry wrong");
endmodule : serial_flash_read_path

//--- testbench/flash_host_model.sv
// serial flash host controller model that drives the read path link
`timescale 1ns/1ps
module flash_host_model (
   output logic o_sck,
   output logic o_cs_n,
   output logic [3:0] o_dq,
   input wire logic [3:0] i_dq,
   input wire logic [3:0] i_dq_oe
);
   // ==========================================
   // link timing: 6 ns clock, lines change only while the clock is low
   initial begin
      o_sck = 1'b0;
      o_cs_n = 1'b1;
      o_dq = 4'h0;
   end

   task automatic pulse();
      #3;
      o_sck = 1'b1;
      #3;
      o_sck = 1'b0;
   endtask : pulse

   task automatic send(input logic [31:0] v, input int nbits, input int w);
      for (int i = nbits - w; i >= 0; i -= w) begin
         o_dq = 4'((v >> i) & ((32'h1 << w) - 1));
         pulse();
      end
   endtask : send

   task automatic frame(input int cw, input logic [7:0] code, input logic [31:0] addr, input int abits,
                        input int aw, input int dmy, input int dw, input int n,
                        output logic [63:0] got, output logic [3:0] oe);
      got = 64'h0;
      oe = 4'h0;
      // link config flops only move on link edges, so give two while deselected
      pulse();
      pulse();
      o_cs_n = 1'b0;
      send({24'h0, code}, 8, cw);
      send(addr, abits, aw);
      // released lines toggle so a stale address bit cannot pass for data
      repeat (dmy + 1) begin
         o_dq = ~o_dq;
         pulse();
      end
      for (int i = 0; i < n * 8 / dw; i++) begin
         o_dq = ~o_dq;
         #3;
         oe |= i_dq_oe;
         got = (got << dw) | 64'(dw == 1 ? {3'h0, i_dq[1]} : i_dq & 4'((1 << dw) - 1));
         o_sck = 1'b1;
         #3;
         o_sck = 1'b0;
      end
      #3;
      o_cs_n = 1'b1;
      #3;
   endtask : frame
endmodule : flash_host_model

//--- testbench/tb_serial_flash_read_path.sv
// self-checking testbench for the serial flash read path
`timescale 1ns/1ps
module tb_serial_flash_read_path;
   logic clk_sys = 1'b0;
   logic reset = 1'b1;
   logic dtr = 1'b0;
   logic addr4_nv = 1'b0;
   logic addr4_enter = 1'b0;
   logic addr4_exit = 1'b0;
   logic [1:0] protocol = 2'h0;
   logic [7:0] ext_addr = 8'h01;
   logic [7:0] param_addr = 8'h00;
   logic sck, cs_n, addr4, read_active;
   logic [3:0] dq_in, dq_out, dq_oe;
   logic [flash_read_pkg::MEM_ADDR_W-1:0] mem_addr;
   logic [7:0] mem_data, param_data;
   int mismatches = 0;
   int cmp_count = 0;

   function automatic logic [7:0] mem(input logic [24:0] a);
      return a[7:0] ^ a[15:8] ^ a[24:17];
   endfunction : mem

   assign mem_data = mem(mem_addr);

   initial begin
      forever #50 clk_sys = ~clk_sys;
   end

   serial_flash_read_path u_dut (.I_CLK_SYS(clk_sys), .I_RESET(reset), .I_SCK(sck), .I_CS_N(cs_n),
      .I_DQ(dq_in), .O_DQ(dq_out), .O_DQ_OE(dq_oe), .O_MEM_ADDR(mem_addr), .I_MEM_DATA(mem_data),
      .I_PROTOCOL(protocol), .I_DTR(dtr), .I_ADDR4_NV(addr4_nv), .I_ADDR4_ENTER(addr4_enter),
      .I_ADDR4_EXIT(addr4_exit), .I_EXT_ADDR(ext_addr), .I_PARAM_ADDR(param_addr),
      .O_PARAM_DATA(param_data), .O_ADDR4(addr4), .O_READ_ACTIVE(read_active));

   flash_host_model u_host (.o_sck(sck), .o_cs_n(cs_n), .o_dq(dq_in), .i_dq(dq_out), .i_dq_oe(dq_oe));

   // ==========================================
   // compares and closing
   task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
      cmp_count++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask : chk_byte

   task automatic chk_bits(input string what, input logic [3:0] exp, input logic [3:0] got);
      cmp_count++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask : chk_bits

   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : end_sim

   // ==========================================
   // scenarios
   task automatic rd(input logic [1:0] p, input logic d, input logic [7:0] code, input int aw, input int dw,
                     input int dmy, input logic [31:0] a, input int abits, input int n);
      logic [63:0] got;
      logic [3:0] oe;
      logic [24:0] m;
      // config crosses into the link domain, so settle it well before the frame
      @(posedge clk_sys);
      protocol <= p;
      dtr <= d;
      repeat (4) @(posedge clk_sys);
      m = abits == 24 ? {ext_addr[0], a[23:0]} : a[24:0];
      u_host.frame(p == 2'h0 ? 1 : p == 2'h1 ? 2 : 4, code, a, abits, aw, dmy, dw == 0 ? 1 : dw, n, got, oe);
      chk_bits("oe", dw == 0 ? 4'h0 : dw == 1 ? 4'h2 : dw == 2 ? 4'h3 : 4'hf, oe);
      chk_bits("oe_idle", 4'h0, dq_oe);
      for (int i = 0; i < n && dw != 0; i++) begin
         chk_byte("data", mem(m + 25'(i)), got[8 * (n - 1 - i) +: 8]);
      end
   endtask : rd

   task automatic t_table();
      logic [15:0] tbl [17] = '{16'h3829, 16'h39eb, 16'h3a27, 16'h3b6b, 16'h3c08, 16'h3e27, 16'h3fbb, 16'h40ff,
         16'h41ff, 16'h4627, 16'h47bb, 16'h4a29, 16'h4beb, 16'h4c0c, 16'h4e10, 16'h4fd8, 16'h5300};
      foreach (tbl[i]) begin
         @(posedge clk_sys);
         param_addr <= tbl[i][15:8];
         @(posedge clk_sys);
         #1;
         chk_byte("param", tbl[i][7:0], param_data);
      end
      $display("test table done");
   endtask : t_table

   task automatic t_cmds();
      // 3-byte address crosses a carry; dw 0 marks a code that must be refused
      rd(2'h0, 1'b0, 8'h03, 1, 1, 0, 32'hc0fffe, 24, 3);
      rd(2'h0, 1'b0, 8'h0b, 1, 1, 8, 32'hc0fffe, 24, 2);
      rd(2'h0, 1'b0, 8'h3b, 1, 2, 8, 32'hc0fffe, 24, 2);
      rd(2'h0, 1'b0, 8'hbb, 2, 2, 7, 32'hc0fffe, 24, 2);
      rd(2'h0, 1'b0, 8'h6b, 1, 4, 7, 32'hc0fffe, 24, 2);
      rd(2'h0, 1'b0, 8'heb, 4, 4, 9, 32'hc0fffe, 24, 2);
      rd(2'h0, 1'b0, 8'h0d, 1, 0, 0, 32'hc0fffe, 24, 2);
      rd(2'h0, 1'b1, 8'h0d, 1, 1, 8, 32'hc0fffe, 24, 2);
      rd(2'h0, 1'b1, 8'h3d, 1, 2, 8, 32'hc0fffe, 24, 2);
      rd(2'h0, 1'b1, 8'hbd, 2, 2, 7, 32'hc0fffe, 24, 2);
      rd(2'h0, 1'b1, 8'h6d, 1, 4, 7, 32'hc0fffe, 24, 2);
      rd(2'h0, 1'b1, 8'hed, 4, 4, 9, 32'hc0fffe, 24, 2);
      rd(2'h0, 1'b1, 8'h03, 1, 0, 0, 32'hc0fffe, 24, 2);
      rd(2'h1, 1'b0, 8'h0b, 2, 2, 7, 32'hc0fffe, 24, 2);
      rd(2'h1, 1'b0, 8'h3b, 2, 2, 8, 32'hc0fffe, 24, 2);
      rd(2'h1, 1'b0, 8'hbb, 2, 2, 7, 32'hc0fffe, 24, 2);
      rd(2'h1, 1'b0, 8'h6b, 2, 0, 0, 32'hc0fffe, 24, 2);
      rd(2'h1, 1'b0, 8'h03, 2, 0, 0, 32'hc0fffe, 24, 2);
      rd(2'h2, 1'b0, 8'h0b, 4, 4, 9, 32'hc0fffe, 24, 2);
      rd(2'h2, 1'b0, 8'h6b, 4, 4, 7, 32'hc0fffe, 24, 2);
      rd(2'h2, 1'b0, 8'heb, 4, 4, 9, 32'hc0fffe, 24, 2);
      rd(2'h2, 1'b0, 8'h3b, 4, 0, 0, 32'hc0fffe, 24, 2);
      rd(2'h2, 1'b1, 8'hed, 4, 4, 9, 32'hc0fffe, 24, 2);
      rd(2'h3, 1'b0, 8'h0b, 4, 0, 0, 32'hc0fffe, 24, 2);
      $display("test commands done");
   endtask : t_cmds

   task automatic mode4(input logic enter);
      @(posedge clk_sys);
      addr4_enter <= enter;
      addr4_exit <= !enter;
      @(posedge clk_sys);
      addr4_enter <= 1'b0;
      addr4_exit <= 1'b0;
      repeat (3) @(posedge clk_sys);
      chk_bits("addr4", {3'h0, enter}, {3'h0, addr4});
   endtask : mode4

   task automatic t_addr4();
      mode4(1'b1);
      fork
         rd(2'h0, 1'b0, 8'h03, 1, 1, 0, 32'h01ffffff, 32, 6);
         begin
            repeat (9) @(posedge clk_sys);
            #1;
            chk_bits("active", 4'h1, {3'h0, read_active});
         end
      join
      repeat (3) @(posedge clk_sys);
      #1;
      chk_bits("active_end", 4'h0, {3'h0, read_active});
      mode4(1'b0);
      $display("test four byte done");
   endtask : t_addr4

   task automatic t_reset_nv();
      @(posedge clk_sys);
      addr4_nv <= 1'b1;
      reset <= 1'b1;
      repeat (3) @(posedge clk_sys);
      #1;
      chk_byte("param_rst", 8'hff, param_data);
      @(posedge clk_sys);
      reset <= 1'b0;
      @(posedge clk_sys);
      #1;
      chk_bits("addr4_nv", 4'h1, {3'h0, addr4});
      $display("test reset mode done");
   endtask : t_reset_nv

   initial begin
      repeat (3) @(posedge clk_sys);
      reset <= 1'b0;
      @(posedge clk_sys);
      #1;
      chk_bits("addr4_rst", 4'h0, {3'h0, addr4});
      t_table();
      t_cmds();
      t_addr4();
      t_reset_nv();
      end_sim();
   end

   // the tests need some 24 us; a hang is cut off well beyond that
   initial begin
      #1000000;
      mismatches++;
      end_sim();
   end
endmodule : tb_serial_flash_read_path
